// ---- common/ftpm_pkg.sv ----
// How it works
// - two mode bits pick analog or tach
// - mode bits reset to zero, tach inputs
// - timebase gated into 8-bit counter, period
// - start bit one, int clear zero starts
// - measure from rising edge to second next
// - fans measured in turn, end early saturated
// - full scale is 255, period too long
// - latest count kept in per-fan value registers
// - prescaler divides by 1,2,4,8, reset two
// - count equals timebase*60 over rpm*divisor
// - divisors in upper nibble beside vid bits
// - fail flag when count exceeds low-speed limit
// - analog sequence kicked together, then independent
`default_nettype none
package ftpm_pkg;
  // clock and timebase
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned TIMEBASE_HZ = 22_500;
  localparam int unsigned TB_CYCLES   = (CLK_HZ + TIMEBASE_HZ / 2) / TIMEBASE_HZ;
  localparam int unsigned NUM_FANS    = 2;
  // register byte addresses
  localparam logic [7:0] ADR_CONFIG = 8'h00;
  localparam logic [7:0] ADR_MODE   = 8'h04;
  localparam logic [7:0] ADR_DIV    = 8'h08;
  localparam logic [7:0] ADR_VALUE0 = 8'h0C;
  localparam logic [7:0] ADR_VALUE1 = 8'h10;
  localparam logic [7:0] ADR_LIMIT0 = 8'h14;
  localparam logic [7:0] ADR_LIMIT1 = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1C;
  localparam logic [7:0] ADR_MASK   = 8'h20;
  // configuration fields
  localparam int unsigned CFG_START_BIT  = 0;
  localparam int unsigned CFG_INTEN_BIT  = 1;
  localparam int unsigned CFG_INTCLR_BIT = 3;
  localparam int unsigned DIV_LSB        = 4;
  // reset values
  localparam logic [3:0] CFG_RST   = 4'h0;
  localparam logic [1:0] MODE_RST  = 2'h0;
  localparam logic [3:0] DIV_RST   = 4'h5;
  localparam logic [7:0] LIMIT_RST = 8'hFF;
  localparam logic [7:0] VALUE_RST = 8'h00;
  localparam logic [1:0] MASK_RST  = 2'h0;
  localparam logic [7:0] CNT_FULL  = 8'hFF;
  // fan sequencer states
  typedef enum {ST_IDLE, ST_PICK, ST_ARM, ST_MEAS, ST_STORE} ftpm_state_type;
endpackage : ftpm_pkg
`default_nettype wire

// ---- rtl/fan_tach_period_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module fan_tach_period_monitor #(
  parameter int unsigned TB_CYCLES = ftpm_pkg::TB_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tach_input_first_i,
  input  wire logic        tach_input_second_i,
  input  wire logic [3:0]  vid_i,
  output logic      [1:0]  analog_sel_o,
  output logic             conv_start_o,
  output logic             irq_o
);

  // bus and register state
  logic                   ack_q;
  logic [31:0]            dat_q;
  logic [3:0]             cfg_q;
  logic [1:0]             mode_q;
  logic [3:0]             div_q;
  logic [7:0]             value_q [2];
  logic [7:0]             limit_q [2];
  logic [1:0]             status_q;
  logic [1:0]             mask_q;
  logic                   active_q;
  logic                   conv_start_q;
  // input synchronisers
  logic [1:0]             tach_s1_q;
  logic [1:0]             tach_s2_q;
  logic [1:0]             tach_s3_q;
  logic [3:0]             vid_s1_q;
  logic [3:0]             vid_s2_q;
  // timebase, prescaler and sequencer
  logic [15:0]            tb_cnt_q;
  logic [2:0]             pre_q;
  logic [7:0]             cnt_q;
  logic                   edge_q;
  logic                   idx_q;
  ftpm_pkg::ftpm_state_type st_q;

  // bus decode
  wire        bus_hit   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        bus_wr    = bus_hit & wb_we_i & wb_sel_i[0];
  wire        bus_rd    = bus_hit & ~wb_we_i;
  wire        hit_cfg   = wb_adr_i == ftpm_pkg::ADR_CONFIG;
  wire        hit_mode  = wb_adr_i == ftpm_pkg::ADR_MODE;
  wire        hit_div   = wb_adr_i == ftpm_pkg::ADR_DIV;
  wire        hit_val0  = wb_adr_i == ftpm_pkg::ADR_VALUE0;
  wire        hit_val1  = wb_adr_i == ftpm_pkg::ADR_VALUE1;
  wire        hit_lim0  = wb_adr_i == ftpm_pkg::ADR_LIMIT0;
  wire        hit_lim1  = wb_adr_i == ftpm_pkg::ADR_LIMIT1;
  wire        hit_stat  = wb_adr_i == ftpm_pkg::ADR_STATUS;
  wire        hit_mask  = wb_adr_i == ftpm_pkg::ADR_MASK;
  wire        stat_rd   = bus_rd & hit_stat;

  // read data mux, unmapped addresses read zero
  wire [31:0] rd_data =
      hit_cfg  ? {28'h0000000, cfg_q} :
      hit_mode ? {30'h0, mode_q} :
      hit_div  ? {24'h000000, div_q, vid_s2_q} :
      hit_val0 ? {24'h000000, value_q[0]} :
      hit_val1 ? {24'h000000, value_q[1]} :
      hit_lim0 ? {24'h000000, limit_q[0]} :
      hit_lim1 ? {24'h000000, limit_q[1]} :
      hit_stat ? {30'h0, status_q} :
      hit_mask ? {30'h0, mask_q} : 32'h00000000;

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign analog_sel_o = mode_q;
  assign conv_start_o = conv_start_q;

  // monitoring runs while start is set and int clear is low
  wire active_now = cfg_q[ftpm_pkg::CFG_START_BIT] & ~cfg_q[ftpm_pkg::CFG_INTCLR_BIT];

  // interrupt: unmasked sticky status, gated by enable and clear
  assign irq_o = |(status_q & ~mask_q) & cfg_q[ftpm_pkg::CFG_INTEN_BIT]
                 & ~cfg_q[ftpm_pkg::CFG_INTCLR_BIT];

  // single-cycle ack and registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_hit;
      if (bus_hit) begin
        dat_q <= rd_data;
      end
    end
  end

  // software-written control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q      <= ftpm_pkg::CFG_RST;
      mode_q     <= ftpm_pkg::MODE_RST;
      div_q      <= ftpm_pkg::DIV_RST;
      limit_q[0] <= ftpm_pkg::LIMIT_RST;
      limit_q[1] <= ftpm_pkg::LIMIT_RST;
      mask_q     <= ftpm_pkg::MASK_RST;
    end else if (bus_wr) begin
      if (hit_cfg)  cfg_q      <= wb_dat_i[3:0];
      if (hit_mode) mode_q     <= wb_dat_i[1:0];
      if (hit_div)  div_q      <= wb_dat_i[ftpm_pkg::DIV_LSB +: 4];
      if (hit_lim0) limit_q[0] <= wb_dat_i[7:0];
      if (hit_lim1) limit_q[1] <= wb_dat_i[7:0];
      if (hit_mask) mask_q     <= wb_dat_i[1:0];
    end
  end

  // start pulse shared with the analog conversion sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q     <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      active_q     <= active_now;
      conv_start_q <= active_now & ~active_q;
    end
  end

  // two-flop synchronisers plus one stage for edge detection
  genvar g;
  generate
    for (g = 0; g < ftpm_pkg::NUM_FANS; g++) begin : g_tach
      wire tach_pin = (g == 0) ? tach_input_first_i : tach_input_second_i;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tach_s1_q[g] <= 1'b0;
          tach_s2_q[g] <= 1'b0;
          tach_s3_q[g] <= 1'b0;
        end else begin
          tach_s1_q[g] <= tach_pin;
          tach_s2_q[g] <= tach_s1_q[g];
          tach_s3_q[g] <= tach_s2_q[g];
        end
      end
    end
  endgenerate

  // voltage id bits share the divisor register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vid_s1_q <= 4'h0;
      vid_s2_q <= 4'h0;
    end else begin
      vid_s1_q <= vid_i;
      vid_s2_q <= vid_s1_q;
    end
  end

  // free-running timebase tick
  wire tb_tick = tb_cnt_q == 16'(TB_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || tb_tick) begin
      tb_cnt_q <= 16'h0000;
    end else begin
      tb_cnt_q <= tb_cnt_q + 16'h0001;
    end
  end

  // prescaler for the selected fan
  wire [1:0] div_sel  = idx_q ? div_q[3:2] : div_q[1:0];
  wire [2:0] pre_mask = 3'((4'h1 << div_sel) - 4'h1);
  wire       cnt_tick = tb_tick & ((pre_q & pre_mask) == pre_mask);
  wire       cur_rise = tach_s2_q[idx_q] & ~tach_s3_q[idx_q];
  wire       cnt_full = cnt_q == ftpm_pkg::CNT_FULL;
  wire [7:0] cnt_inc  = cnt_full ? cnt_q : cnt_q + 8'h01;
  wire       restart  = (st_q == ftpm_pkg::ST_PICK) | ((st_q == ftpm_pkg::ST_ARM) & cur_rise);

  // prescaler and saturating period counter
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      pre_q <= 3'h0;
      cnt_q <= 8'h00;
    end else begin
      if (tb_tick) pre_q <= pre_q + 3'h1;
      if (cnt_tick) cnt_q <= cnt_inc;
    end
  end

  // fan sequencer: pick, wait edge, measure two periods, store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= ftpm_pkg::ST_IDLE;
      idx_q  <= 1'b0;
      edge_q <= 1'b0;
    end else if (!active_q) begin
      st_q   <= ftpm_pkg::ST_IDLE;
      idx_q  <= 1'b0;
    end else begin
      case (st_q)
        ftpm_pkg::ST_IDLE: begin
          st_q <= ftpm_pkg::ST_PICK;
        end
        ftpm_pkg::ST_PICK: begin
          edge_q <= 1'b0;
          if (mode_q[idx_q]) idx_q <= ~idx_q;
          else st_q <= ftpm_pkg::ST_ARM;
        end
        ftpm_pkg::ST_ARM: begin
          if (cur_rise) st_q <= ftpm_pkg::ST_MEAS;
          else if (cnt_full) st_q <= ftpm_pkg::ST_STORE;
        end
        ftpm_pkg::ST_MEAS: begin
          if (cur_rise) begin
            edge_q <= 1'b1;
            if (edge_q) st_q <= ftpm_pkg::ST_STORE;
          end
          if (cnt_full) st_q <= ftpm_pkg::ST_STORE;
        end
        ftpm_pkg::ST_STORE: begin
          idx_q <= ~idx_q;
          st_q  <= ftpm_pkg::ST_PICK;
        end
        default: begin
          st_q <= ftpm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // result store and limit compare per fan
  wire [1:0] store_en;
  wire [1:0] fail_set;
  generate
    for (g = 0; g < ftpm_pkg::NUM_FANS; g++) begin : g_fan
      assign store_en[g] = (st_q == ftpm_pkg::ST_STORE) & (idx_q == 1'(g)) & ~mode_q[g];
      assign fail_set[g] = store_en[g] & (cnt_q > limit_q[g]);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          value_q[g] <= ftpm_pkg::VALUE_RST;
        end else if (store_en[g]) begin
          value_q[g] <= cnt_q;
        end
      end
    end
  endgenerate

  // sticky status, cleared by a read, a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= 2'h0;
    end else begin
      status_q <= (status_q & ~{2{stat_rd}}) | fail_set;
    end
  end

  // checks next to the logic they guard
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

  a_reset_defaults: assert property (@(posedge clk_i)
    rst_i |=> (mode_q == 2'h0) && (div_q == 4'h5))
    else $error("mode or divisor reset value wrong");

  a_start_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_start_q == $rose(active_q))
    else $error("conversion start not aligned to monitoring start");

  a_start_cond: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(active_q) |-> $past(cfg_q[0]) && !$past(cfg_q[3]))
    else $error("monitoring began without start and clear low");

  a_sat_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ftpm_pkg::ST_MEAS && cnt_q == 8'hFF && active_q) |=> st_q == ftpm_pkg::ST_STORE)
    else $error("full scale did not end measurement");

  a_third_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ftpm_pkg::ST_MEAS && cur_rise && edge_q && active_q)
    |=> st_q == ftpm_pkg::ST_STORE ##1 (st_q == ftpm_pkg::ST_PICK || !$past(active_q)))
    else $error("measurement did not end on third rising edge");

  a_store_value: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ftpm_pkg::ST_STORE && !idx_q && !mode_q[0] && active_q)
    |=> value_q[0] == $past(cnt_q))
    else $error("first fan value not stored");

  a_skip_analog: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_q[1] && idx_q) |=> $stable(value_q[1]))
    else $error("analog slot value changed");

  a_fail_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ftpm_pkg::ST_STORE && idx_q && !mode_q[1] && active_q && cnt_q > limit_q[1])
    |=> status_q[1])
    else $error("fan failure not flagged");

  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> cfg_q[1] && !cfg_q[3] && (status_q & ~mask_q) != 2'h0)
    else $error("interrupt raised while gated off");

  a_count_sat: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_q == 8'hFF && !restart) |=> cnt_q == 8'hFF)
    else $error("counter wrapped past full scale");

endmodule : fan_tach_period_monitor
`default_nettype wire

// ---- tb/ftpm_fan_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// fan tach source: square wave of programmable period
module ftpm_fan_model (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [15:0] period_i,
  output logic             tach_o
);
  logic [15:0] cnt_q = 16'h0000;
  // period counter runs only while the rotor turns
  always @(posedge clk_i) begin
    if (!run_i || cnt_q >= period_i - 16'h0001) cnt_q <= 16'h0000;
    else cnt_q <= cnt_q + 16'h0001;
  end
  // a stalled rotor leaves the line low, so no edges reach the counter
  assign tach_o = run_i && (cnt_q < (period_i >> 1));
endmodule : ftpm_fan_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  vid = 4'hA;
  logic [1:0]  asel;
  logic        conv;
  logic        irq;
  logic        run1 = 1'b1;
  logic        tach1;
  logic        tach2;
  logic [7:0]  d;
  logic [7:0]  v1;
  int          err_count = 0;
  int          n_checks = 0;
  int          n_conv = 0;
  int          cycles = 0;
  int          k;

  always #4 clk = ~clk;

  // short timebase keeps counts small: one tick every 4 clocks
  fan_tach_period_monitor #(.TB_CYCLES(4)) i_dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tach_input_first_i(tach1), .tach_input_second_i(tach2), .vid_i(vid),
    .analog_sel_o(asel), .conv_start_o(conv), .irq_o(irq));
  // fan one 400 clocks a period, fan two 800
  ftpm_fan_model i_tach_input_first (.clk_i(clk), .run_i(run1), .period_i(16'h0190), .tach_o(tach1));
  ftpm_fan_model i_tach_input_second (.clk_i(clk), .run_i(1'b1), .period_i(16'h0320), .tach_o(tach2));

  // cycle tally, start pulse tally and hang cutoff
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (conv === 1'b1) n_conv <= n_conv + 1;
    if (cycles == 60000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // counts carry a tick or two of phase jitter
  task automatic near(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if ($isunknown(got) || got < exp - 8'h02 || got > exp + 8'h02) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : near

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, wd};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] unused;
    bus(1'b1, a, v, unused);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, d);
    chk(what, exp, d);
  endtask : rd_chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk("config", ftpm_pkg::ADR_CONFIG, 8'h00);
    rd_chk("mode", ftpm_pkg::ADR_MODE, 8'h00);
    rd_chk("divisor", ftpm_pkg::ADR_DIV, {4'h5, vid});
    rd_chk("value1", ftpm_pkg::ADR_VALUE0, 8'h00);
    rd_chk("limit1", ftpm_pkg::ADR_LIMIT0, 8'hFF);
    rd_chk("status", ftpm_pkg::ADR_STATUS, 8'h00);
    rd_chk("unmapped", 8'h24, 8'h00);
    $display("test reset done");
    wr(ftpm_pkg::ADR_LIMIT0, 8'h96);
    wr(ftpm_pkg::ADR_LIMIT1, 8'h6E);
    wr(ftpm_pkg::ADR_DIV, 8'h80);
    wr(ftpm_pkg::ADR_CONFIG, 8'h03);
    repeat (8000) @(posedge clk);
    chk("start pulses", 8'h01, n_conv[7:0]);
    bus(1'b0, ftpm_pkg::ADR_VALUE0, 8'h00, d);
    near("tach_input_first count", 8'hC8, d);
    bus(1'b0, ftpm_pkg::ADR_VALUE1, 8'h00, v1);
    near("tach_input_second count", 8'h64, v1);
    chk("irq raised", 8'h01, {7'h00, irq});
    rd_chk("status", ftpm_pkg::ADR_STATUS, 8'h01);
    wr(ftpm_pkg::ADR_MASK, 8'h01);
    @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    $display("test measure done");
    wr(ftpm_pkg::ADR_MODE, 8'h02);
    @(posedge clk);
    chk("analog select", 8'h02, {6'h00, asel});
    for (k = 0; k < 4; k++) begin
      wr(ftpm_pkg::ADR_DIV, 8'(k << 4));
      repeat (3000) @(posedge clk);
      bus(1'b0, ftpm_pkg::ADR_VALUE0, 8'h00, d);
      near("tach_input_first prescaled", 8'(200 >> k), d);
    end
    rd_chk("tach_input_second kept", ftpm_pkg::ADR_VALUE1, v1);
    $display("test prescaler done");
    wr(ftpm_pkg::ADR_MODE, 8'h00);
    run1 <= 1'b0;
    wr(ftpm_pkg::ADR_DIV, 8'h00);
    repeat (6000) @(posedge clk);
    rd_chk("tach_input_first stalled", ftpm_pkg::ADR_VALUE0, 8'hFF);
    rd_chk("tach_input_second too slow", ftpm_pkg::ADR_VALUE1, 8'hFF);
    chk("irq unmasked tach_input_second", 8'h01, {7'h00, irq});
    $display("test saturation done");
    wr(ftpm_pkg::ADR_CONFIG, 8'h0B);
    @(posedge clk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    run1 <= 1'b1;
    repeat (3000) @(posedge clk);
    rd_chk("tach_input_first frozen", ftpm_pkg::ADR_VALUE0, 8'hFF);
    $display("test stop done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
